// file: ahl_params.svh
/*
 * constants of the alarm history logger: timing figures and counts.
 * assumes it is included by bare name wherever the figures are needed.
 */
`ifndef AHL_PARAMS_SVH
`define AHL_PARAMS_SVH

// ==========================================================
// clock and time base
`define AHL_CLK_HZ 125000000
`define AHL_TICK_MS 100
`define AHL_TICK_CYCLES ((`AHL_CLK_HZ / 1000) * `AHL_TICK_MS)

// ==========================================================
// repeat window: one hour expressed in time-base ticks
`define AHL_REPEAT_S 3600
`define AHL_REPEAT_TICKS ((`AHL_REPEAT_S * 1000) / `AHL_TICK_MS)

// ==========================================================
// history shape
`define AHL_DEPTH 10
`define AHL_CODE_W 12
`define AHL_TIME_W 32

`endif

// file: ahl_pkg.sv
/*
 * types shared by the alarm history logger.
 * assumes ahl_params.svh is on the include path.
 */
`include "ahl_params.svh"

package ahl_pkg;
  // 32 bits of 100 ms ticks last about 13.6 years
  typedef logic [`AHL_TIME_W-1:0] ahl_time_t;
  typedef logic [3:0] ahl_index_t;
endpackage

// file: ahl_logger.sv
/*
 * alarm history logger: operating-time counter, ten-deep alarm history with
 * repeat suppression, clear command and newest-first read port.
 * assumes all inputs are synchronous to sys_clk and that a non-volatile copy,
 * if any, is kept outside; sys_rst stands for loss of control supply.
 */
// Operation
// - keep the ten most recent alarms, each with code and time stamp
// - operating time counts 100 ms steps while control and main power on
// - a logged alarm stores the current operating time as its stamp
// - operating time counter spans about 13 years without overflow
// - same code again within one hour of operating time is discarded
// - reading an empty position returns a distinct empty indication
// - only the clear command or sys_rst (control supply loss) erases history; alarm reset and main power loss keep it
`timescale 1ns/1ps
`include "ahl_params.svh"

module ahl_logger
  import ahl_pkg::*;
#(
  parameter int DEPTH = `AHL_DEPTH,
  parameter int CODE_W = `AHL_CODE_W,
  parameter int TICK_CYCLES = `AHL_TICK_CYCLES,
  parameter int REPEAT_TICKS = `AHL_REPEAT_TICKS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // supply status
  input wire logic ctrl_power_on,
  input wire logic main_power_on,
  // alarm events
  input wire logic alarm_valid,
  input wire logic [CODE_W-1:0] alarm_code,
  input wire logic alarm_reset,
  // history_clear_function command
  input wire logic history_clear,
  // alarm_history_view read port
  input wire logic view_req,
  input wire logic [3:0] view_index,
  output logic view_ack,
  output logic view_empty,
  output logic [CODE_W-1:0] view_code,
  output ahl_time_t view_stamp,
  // status
  output logic [3:0] entry_count,
  output ahl_time_t op_time
);

  // ==========================================================
  // elaboration checks
  // the shift check needs two slots and the count and index ports are 4 bits wide
  if (DEPTH < 2 || DEPTH > 15) begin : g_bad_depth
    $error("DEPTH must be 2 to 15");
  end
  if (TICK_CYCLES > 16777216) begin : g_bad_tick
    $error("TICK_CYCLES must fit the 24-bit prescaler");
  end
  if (CODE_W < 1) begin : g_bad_code
    $error("CODE_W must be positive");
  end
  if (TICK_CYCLES < 1 || REPEAT_TICKS < 1) begin : g_bad_time
    $error("TICK_CYCLES and REPEAT_TICKS must be positive");
  end

  localparam ahl_time_t TIME_MAX = '1;
  localparam logic [3:0] DEPTH_C = 4'(DEPTH);
  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
  localparam ahl_time_t REPEAT_C = ahl_time_t'(REPEAT_TICKS);

  // ==========================================================
  // operating-time base
  logic [23:0] presc;
  wire powered = ctrl_power_on & main_power_on;
  wire tick = powered & (presc == TICK_LAST);
  wire time_full = (op_time == TIME_MAX);

  // prescaler holds while either supply is off so partial steps are kept
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc <= 24'h000000;
    end else if (powered) begin
      presc <= tick ? 24'h000000 : presc + 24'h000001;
    end
  end

  // saturates rather than wrapping, so stamps never run backwards
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_time <= '0;
    end else if (tick && !time_full) begin
      op_time <= op_time + 32'h00000001;
    end
  end

  // ==========================================================
  // history storage, entry 0 newest
  logic [CODE_W-1:0] hist_code [DEPTH];
  ahl_time_t hist_stamp [DEPTH];
  logic [DEPTH-1:0] recent;

  // a match on any held entry within the window suppresses the repeat
  for (genvar i = 0; i < DEPTH; i++) begin : g_match
    wire held = (4'(i) < entry_count);
    wire same = (hist_code[i] == alarm_code);
    wire ahl_time_t age = op_time - hist_stamp[i];
    assign recent[i] = held & same & (age <= REPEAT_C);
  end

  // a clear in the same cycle empties first, so the new alarm is still kept
  wire suppress = (|recent) & ~history_clear;
  wire log_en = alarm_valid & ~suppress;
  wire [3:0] base_count = history_clear ? 4'h0 : entry_count;
  wire [3:0] next_count = log_en ? ((base_count == DEPTH_C) ? DEPTH_C : base_count + 4'h1)
                                 : base_count;

  // alarm_reset is deliberately not used here: the history outlives it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      entry_count <= 4'h0;
    end else begin
      entry_count <= next_count;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    if (i == 0) begin : g_head
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          hist_code[i] <= '0;
          hist_stamp[i] <= '0;
        end else if (log_en) begin
          hist_code[i] <= alarm_code;
          hist_stamp[i] <= op_time;
        end
      end
    end else begin : g_tail
      // each older slot takes its younger neighbour; the oldest simply falls off
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          hist_code[i] <= '0;
          hist_stamp[i] <= '0;
        end else if (log_en) begin
          hist_code[i] <= hist_code[i-1];
          hist_stamp[i] <= hist_stamp[i-1];
        end
      end
    end
  end

  // ==========================================================
  // read port
  // a read in the same cycle as a log sees the contents before the shift
  wire view_hit = (view_index < entry_count);
  wire [3:0] view_sel = view_hit ? view_index : 4'h0;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      view_ack <= 1'b0;
      view_empty <= 1'b0;
      view_code <= '0;
      view_stamp <= '0;
    end else begin
      view_ack <= view_req;
      if (view_req) begin
        view_empty <= ~view_hit;
        view_code <= view_hit ? hist_code[view_sel] : '0;
        view_stamp <= view_hit ? hist_stamp[view_sel] : '0;
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  AST_COUNT_BOUND: assert property (entry_count <= DEPTH_C)
    else $error("entry count above depth");
  AST_TIME_STEP: assert property (tick && !time_full |=> op_time == $past(op_time) + 1)
    else $error("operating time did not step on tick");
  AST_TIME_HOLD: assert property (!powered |=> $stable(op_time))
    else $error("operating time moved with supply off");
  AST_TIME_SAT: assert property (time_full |=> op_time == TIME_MAX)
    else $error("operating time wrapped");
  AST_STAMP: assert property (log_en |=> hist_stamp[0] == $past(op_time)
                              && hist_code[0] == $past(alarm_code))
    else $error("stamp or code not captured");
  AST_REPEAT: assert property (alarm_valid && suppress && !history_clear
                               |=> $stable(entry_count) && $stable(hist_code[0]))
    else $error("repeat inside window was logged");
  AST_FRESH: assert property (alarm_valid && !(|recent) && !history_clear
                              && entry_count < DEPTH_C |=> entry_count == $past(entry_count) + 1)
    else $error("new alarm not logged");
  AST_EMPTY: assert property (view_req && view_index >= entry_count
                              |=> view_ack && view_empty && view_code == '0)
    else $error("empty position not reported as empty");
  AST_CLEAR: assert property (history_clear && !alarm_valid |=> entry_count == 4'h0)
    else $error("clear did not empty history");
  AST_KEEP: assert property (!history_clear && !alarm_valid |=> $stable(entry_count))
    else $error("history changed without clear or alarm");
  AST_SHIFT: assert property (log_en |=> hist_code[DEPTH-1] == $past(hist_code[DEPTH-2]))
    else $error("history did not shift");
  AST_ALARM_RESET: assert property (alarm_reset && !alarm_valid && !history_clear
                                    |=> $stable(entry_count) && $stable(hist_code[0]))
    else $error("alarm reset disturbed history");
  AST_ACK: assert property (view_ack == $past(view_req))
    else $error("read answer not one cycle after request");
  AST_VIEW_DATA: assert property (view_req && view_hit |=> !view_empty
                                  && view_code == $past(hist_code[view_sel]))
    else $error("read returned wrong entry");
  // partial steps must survive a supply drop, or short power cycles would lose time
  AST_PRESC_HOLD: assert property (!powered |=> $stable(presc))
    else $error("prescaler moved with supply off");

  COV_FULL: cover property (entry_count == DEPTH_C ##1 log_en);
  COV_SUPPRESS: cover property (alarm_valid && suppress);
  COV_CLEAR_LOG: cover property (history_clear && alarm_valid);
  COV_EMPTY_READ: cover property (view_req && entry_count == 4'h0);
  COV_OLDEST_READ: cover property (view_req && entry_count == DEPTH_C
                                   && view_index == DEPTH_C - 4'h1);

endmodule

// file: tb_top.sv
/*
 * self-checking testbench for ahl_logger: time base, logging, stamps,
 * repeat window, full history, clear and empty reads.
 * assumes ahl_pkg and ahl_params.svh compiled first; short tick and window.
 */
`timescale 1ns/1ps
module tb_top;
  import ahl_pkg::*;
  // ==========================================================
  // signals and design
  localparam int TICK = 4;
  localparam int REP = 5;
  logic sys_clk, sys_rst, ctrl_power_on, main_power_on, alarm_valid, alarm_reset;
  logic history_clear, view_req, view_ack, view_empty;
  logic [11:0] alarm_code, view_code;
  logic [3:0] view_index, entry_count;
  ahl_time_t view_stamp, op_time, t0;
  int miscompares = 0;
  int checks = 0;
  ahl_logger #(.DEPTH(10), .CODE_W(12), .TICK_CYCLES(TICK), .REPEAT_TICKS(REP)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .ctrl_power_on(ctrl_power_on),
    .main_power_on(main_power_on), .alarm_valid(alarm_valid), .alarm_code(alarm_code),
    .alarm_reset(alarm_reset), .history_clear(history_clear), .view_req(view_req),
    .view_index(view_index), .view_ack(view_ack), .view_empty(view_empty),
    .view_code(view_code), .view_stamp(view_stamp), .entry_count(entry_count),
    .op_time(op_time));
  // ==========================================================
  // helpers
  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task log_alarm(input logic [11:0] c);
    alarm_valid = 1'b1;
    alarm_code = c;
    step(1);
    alarm_valid = 1'b0;
    step(1);
  endtask
  task clear_hist();
    history_clear = 1'b1;
    step(1);
    history_clear = 1'b0;
  endtask
  task rd(input logic [3:0] idx, input logic e, input logic [11:0] c, input ahl_time_t s);
    view_req = 1'b1;
    view_index = idx;
    step(1);
    view_req = 1'b0;
    chk({31'h0, view_ack}, 32'h1);
    chk({31'h0, view_empty}, {31'h0, e});
    chk({20'h0, view_code}, {20'h0, c});
    chk(view_stamp, s);
    step(1);
    chk({31'h0, view_ack}, 32'h0);
  endtask
  // stops the time base exactly when op_time reaches the target
  task wait_t(input ahl_time_t v);
    for (int i = 0; i < 200 && op_time !== v; i++) step(1);
    main_power_on = 1'b0;
  endtask
  task close_out();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task test_time();
    rd(4'h0, 1'b1, 12'h000, 32'h0);
    main_power_on = 1'b1;
    step(42);
    chk(op_time, 32'hA);
    main_power_on = 1'b0;
    step(20);
    chk(op_time, 32'hA);
    ctrl_power_on = 1'b0;
    main_power_on = 1'b1;
    step(20);
    chk(op_time, 32'hA);
    {ctrl_power_on, main_power_on} = 2'b10;
    step(1);
    $display("test_time done");
  endtask
  task test_repeat();
    t0 = op_time;
    log_alarm(12'h720);
    chk({28'h0, entry_count}, 32'h1);
    rd(4'h0, 1'b0, 12'h720, t0);
    main_power_on = 1'b1;
    log_alarm(12'h720);
    wait_t(t0 + REP);
    log_alarm(12'h720);
    chk({28'h0, entry_count}, 32'h1);
    main_power_on = 1'b1;
    wait_t(t0 + REP + 1);
    log_alarm(12'h720);
    chk({28'h0, entry_count}, 32'h2);
    rd(4'h0, 1'b0, 12'h720, t0 + REP + 1);
    $display("test_repeat done");
  endtask
  task test_full_keep();
    clear_hist();
    for (int i = 1; i <= 11; i++) log_alarm(12'(i));
    chk({28'h0, entry_count}, 32'hA);
    rd(4'h0, 1'b0, 12'h00B, t0 + REP + 1);
    rd(4'h9, 1'b0, 12'h002, t0 + REP + 1);
    rd(4'hA, 1'b1, 12'h000, 32'h0);
    alarm_reset = 1'b1;
    step(1);
    alarm_reset = 1'b0;
    step(3);
    chk({28'h0, entry_count}, 32'hA);
    {history_clear, alarm_valid} = 2'b11;
    alarm_code = 12'h005;
    step(1);
    {history_clear, alarm_valid} = 2'b00;
    step(1);
    chk({28'h0, entry_count}, 32'h1);
    rd(4'h0, 1'b0, 12'h005, t0 + REP + 1);
    rd(4'h1, 1'b1, 12'h000, 32'h0);
    clear_hist();
    chk({28'h0, entry_count}, 32'h0);
    rd(4'h0, 1'b1, 12'h000, 32'h0);
    $display("test_full_keep done");
  endtask
  // ==========================================================
  // clock, reset, sequence and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    {sys_rst, ctrl_power_on} = 2'b11;
    {main_power_on, alarm_valid, alarm_reset, history_clear, view_req} = 5'h00;
    alarm_code = 12'h000;
    view_index = 4'h0;
    step(5);
    sys_rst = 1'b0;
    step(1);
    test_time();
    test_repeat();
    test_full_keep();
    close_out();
  end
  // the tests need well under 1000 cycles
  initial begin
    #80000;
    miscompares++;
    close_out();
  end
endmodule
